//--- rpz_pkg.sv
// constants for the reference profile zero register bank
// assumes byte-wide registers on a 32-bit apb word grid, 4 bytes per index
package rpz_pkg;

  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_PRIORITY_AND_SCALE = 14'h0600;
  localparam logic [13:0] IDX_REF_PERIOD_B0 = 14'h0601;
  localparam logic [13:0] IDX_REF_PERIOD_B1 = 14'h0602;
  localparam logic [13:0] IDX_REF_PERIOD_B2 = 14'h0603;
  localparam logic [13:0] IDX_REF_PERIOD_B3 = 14'h0604;
  localparam logic [13:0] IDX_REF_PERIOD_B4 = 14'h0605;
  localparam logic [13:0] IDX_SPARE_AFTER_PERIOD_A = 14'h0606;
  localparam logic [13:0] IDX_SPARE_AFTER_PERIOD_B = 14'h0607;
  localparam logic [13:0] IDX_INNER_TOL_B0 = 14'h0608;
  localparam logic [13:0] IDX_INNER_TOL_B1 = 14'h0609;
  localparam logic [13:0] IDX_INNER_TOL_B2 = 14'h060a;
  localparam logic [13:0] IDX_OUTER_TOL_B0 = 14'h060b;
  localparam logic [13:0] IDX_OUTER_TOL_B1 = 14'h060c;
  localparam logic [13:0] IDX_OUTER_TOL_B2 = 14'h060d;
  localparam logic [13:0] IDX_QUALIFY_TIMER_LO = 14'h060e;
  localparam logic [13:0] IDX_QUALIFY_TIMER_HI = 14'h060f;
  localparam logic [13:0] IDX_RECHECK_TIMER_LO = 14'h0610;
  localparam logic [13:0] IDX_RECHECK_TIMER_HI = 14'h0611;
  localparam logic [13:0] IDX_COEF_FIRST_LIN_LO = 14'h0612;
  localparam logic [13:0] IDX_COEF_FIRST_LIN_HI = 14'h0613;
  localparam logic [13:0] IDX_COEF_FIRST_EXPS = 14'h0614;
  localparam logic [13:0] IDX_COEF_SECOND_LIN_A = 14'h0615;
  localparam logic [13:0] IDX_COEF_SECOND_LIN_B = 14'h0616;
  localparam logic [13:0] IDX_COEF_SECOND_EXP = 14'h0617;
  localparam logic [13:0] IDX_COEF_THIRD_LIN_LO = 14'h0618;
  localparam logic [13:0] IDX_COEF_THIRD_LIN_HI = 14'h0619;
  localparam logic [13:0] IDX_COEF_THIRD_EXP = 14'h061a;
  localparam logic [13:0] IDX_COEF_FOURTH_LIN_LO = 14'h061b;
  localparam logic [13:0] IDX_COEF_FOURTH_MIXED = 14'h061c;
  localparam logic [13:0] IDX_COEF_EXPS_TAIL = 14'h061d;
  localparam logic [13:0] IDX_INPUT_PREDIV_B0 = 14'h061e;
  localparam logic [13:0] IDX_INPUT_PREDIV_B1 = 14'h061f;
  localparam logic [13:0] IDX_INPUT_PREDIV_B2 = 14'h0620;
  localparam logic [13:0] IDX_INPUT_PREDIV_B3 = 14'h0621;
  localparam logic [13:0] IDX_FEEDBACK_INT_B0 = 14'h0622;
  localparam logic [13:0] IDX_FEEDBACK_INT_B1 = 14'h0623;
  localparam logic [13:0] IDX_FEEDBACK_INT_B2 = 14'h0624;
  localparam logic [13:0] IDX_SPARE_AFTER_FEEDBACK = 14'h0625;
  localparam logic [13:0] IDX_FRACTION_NUM_LO = 14'h0626;
  localparam logic [13:0] IDX_FRACTION_MIXED = 14'h0627;
  localparam logic [13:0] IDX_FRACTION_MOD_HI = 14'h0628;
  localparam logic [13:0] IDX_APPLY_CTRL = 14'h0700;
  localparam logic [13:0] IDX_BANK_STATUS = 14'h0701;

  localparam int NUM_BYTES = 41;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // field positions and limits
  // ----------------------------------------------------------------
  localparam int SCALE_BIT = 7;
  localparam int PROMO_LSB = 3;
  localparam int SEL_LSB = 0;
  localparam int APPLY_BIT = 0;
  localparam int STS_PENDING_BIT = 0;
  localparam int STS_PROMO_BAD_BIT = 1;
  localparam int STS_FB_LOW_BIT = 2;
  localparam logic [19:0] FB_INT_MIN = 20'h0_0007;
  localparam logic [25:0] NS_TO_PS = 26'h3e8;

  // apb slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } rpz_state_e;

endpackage

//--- rpz_profile_bank.sv
// apb register bank for reference profile zero of a clock synchronizer
// assumes threshold, active flag and lock threshold inputs share clk_i
//
// Overview of operation
// - top bit picks ps or ns
// - low three bits rank the reference
// - promoted priority used while reference active
// - 40-bit period in fs, lsb first
// - inner tolerance is 20 bits
// - outer tolerance is 20 bits
// - 16-bit validation time in ms
// - 16-bit redetect time in ms
// - coefficient is linear times power of two
// - first group: linear plus three exponents
// - second group: 17-bit linear, 5-bit exponent
// - third group: 17-bit linear, 5-bit exponent
// - fourth group: 15-bit linear, split exponent
// - 30-bit pre-divider divides by value plus one
// - 20-bit feedback divides by value plus one
// - fractional divider: two 10-bit fields
// - every profile bit resets to zero
// - priority below threshold means phase master
// - lock threshold scaled by unit bit
`timescale 1ns/10ps
module rpz_profile_bank (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ref_active_i,
  input wire logic [2:0] master_thresh_i,
  input wire logic [15:0] lock_thresh_i,
  output logic scale_ns_o,
  output logic [2:0] promo_prio_o,
  output logic [2:0] sel_prio_o,
  output logic [2:0] eff_prio_o,
  output logic phase_master_o,
  output logic [25:0] lock_thresh_ps_o,
  output logic [39:0] ref_period_fs_o,
  output logic [19:0] inner_tol_o,
  output logic [19:0] outer_tol_o,
  output logic [15:0] qualify_ms_o,
  output logic [15:0] recheck_ms_o,
  output logic [15:0] c1_lin_o,
  output logic [5:0] c1_exp_a_o,
  output logic [2:0] c1_exp_b_o,
  output logic [3:0] c1_exp_c_o,
  output logic [16:0] c2_lin_o,
  output logic [4:0] c2_exp_o,
  output logic [16:0] c3_lin_o,
  output logic [4:0] c3_exp_o,
  output logic [14:0] c4_lin_o,
  output logic [4:0] c4_exp_o,
  output logic [30:0] prediv_ratio_o,
  output logic [20:0] fb_int_ratio_o,
  output logic [9:0] frac_num_o,
  output logic [9:0] frac_mod_o
);

  // ----------------------------------------------------------------
  // writable bits of each byte; unused bits store nothing, read zero
  // ----------------------------------------------------------------
  function automatic logic [7:0] bits_of(input logic [13:0] idx);
    case (idx)
      rpz_pkg::IDX_PRIORITY_AND_SCALE: bits_of = 8'hbf;
      rpz_pkg::IDX_SPARE_AFTER_PERIOD_A: bits_of = 8'h00;
      rpz_pkg::IDX_SPARE_AFTER_PERIOD_B: bits_of = 8'h00;
      rpz_pkg::IDX_INNER_TOL_B2: bits_of = 8'h0f;
      rpz_pkg::IDX_OUTER_TOL_B2: bits_of = 8'h0f;
      rpz_pkg::IDX_COEF_SECOND_EXP: bits_of = 8'h7f;
      rpz_pkg::IDX_COEF_THIRD_EXP: bits_of = 8'h3f;
      rpz_pkg::IDX_INPUT_PREDIV_B3: bits_of = 8'h3f;
      rpz_pkg::IDX_FEEDBACK_INT_B2: bits_of = 8'h0f;
      rpz_pkg::IDX_SPARE_AFTER_FEEDBACK: bits_of = 8'h00;
      rpz_pkg::IDX_FRACTION_MIXED: bits_of = 8'hf3;
      rpz_pkg::IDX_FRACTION_MOD_HI: bits_of = 8'h3f;
      default: bits_of = 8'hff;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  rpz_pkg::rpz_state_e state_q;
  logic [7:0] regs_q [0:rpz_pkg::NUM_BYTES-1];
  logic [327:0] image;
  logic [13:0] idx_w;
  logic [5:0] rel_w;
  logic aligned;
  logic hit_data;
  logic hit_ctrl;
  logic hit_sts;
  logic commit;
  logic wr_data;
  logic apply_now;
  logic pending_q;
  logic [31:0] rd_word;
  logic promo_bad;
  logic fb_low;

  assign idx_w = paddr_i[15:2];
  assign aligned = (paddr_i[1:0] == 2'b00);
  assign rel_w = 6'(idx_w - rpz_pkg::IDX_PRIORITY_AND_SCALE);
  assign hit_data = aligned && (idx_w >= rpz_pkg::IDX_PRIORITY_AND_SCALE)
    && (idx_w <= rpz_pkg::IDX_FRACTION_MOD_HI);
  assign hit_ctrl = aligned && (idx_w == rpz_pkg::IDX_APPLY_CTRL);
  assign hit_sts = aligned && (idx_w == rpz_pkg::IDX_BANK_STATUS);

  // the transfer ends on the edge that sees pready high in st_ack
  assign commit = (state_q == rpz_pkg::ST_ACK) && psel_i && penable_i;
  assign wr_data = commit && pwrite_i && hit_data;
  assign apply_now = commit && pwrite_i && hit_ctrl
    && pwdata_i[rpz_pkg::APPLY_BIT];

  // ----------------------------------------------------------------
  // apb handshake: one wait cycle so read data can come from a flop
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= rpz_pkg::ST_IDLE;
    end else begin
      case (state_q)
        rpz_pkg::ST_IDLE: begin
          if (psel_i && penable_i) begin
            state_q <= rpz_pkg::ST_ACK;
          end
        end
        rpz_pkg::ST_ACK: begin
          state_q <= rpz_pkg::ST_IDLE;
        end
        default: begin
          state_q <= rpz_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_data) begin
      rd_word[7:0] = regs_q[rel_w] & bits_of(idx_w);
    end else if (hit_sts) begin
      rd_word[rpz_pkg::STS_PENDING_BIT] = pending_q;
      rd_word[rpz_pkg::STS_PROMO_BAD_BIT] = promo_bad;
      rd_word[rpz_pkg::STS_FB_LOW_BIT] = fb_low;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if ((state_q == rpz_pkg::ST_IDLE) && psel_i && penable_i) begin
      pready_o <= 1'b1;
      prdata_o <= pwrite_i ? 32'h0000_0000 : rd_word;
      pslverr_o <= !(hit_data || hit_ctrl || hit_sts);
    end else begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // staged byte store
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int k = 0; k < rpz_pkg::NUM_BYTES; k++) begin
        regs_q[k] <= rpz_pkg::RESET_BYTE;
      end
    end else if (wr_data) begin
      // spare bytes keep nothing, so a stray write cannot leak back
      regs_q[rel_w] <= pwdata_i[7:0] & bits_of(idx_w);
    end
  end

  always_comb begin
    image = '0;
    for (int k = 0; k < rpz_pkg::NUM_BYTES; k++) begin
      image[k*8 +: 8] = regs_q[k];
    end
  end

  // staged edits wait here until apply; set wins over clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pending_q <= 1'b0;
    end else if (wr_data) begin
      pending_q <= 1'b1;
    end else if (apply_now) begin
      pending_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // field unpacking
  // ----------------------------------------------------------------
  logic s_scale;
  logic [2:0] s_promo;
  logic [2:0] s_sel;
  logic [39:0] s_period;
  logic [19:0] s_inner;
  logic [19:0] s_outer;
  logic [15:0] s_qualify;
  logic [15:0] s_recheck;
  logic [15:0] s_c1_lin;
  logic [5:0] s_c1_exp_a;
  logic [2:0] s_c1_exp_b;
  logic [3:0] s_c1_exp_c;
  logic [16:0] s_c2_lin;
  logic [4:0] s_c2_exp;
  logic [16:0] s_c3_lin;
  logic [4:0] s_c3_exp;
  logic [14:0] s_c4_lin;
  logic [4:0] s_c4_exp;
  logic [29:0] s_prediv;
  logic [19:0] s_fb_int;
  logic [9:0] s_frac_num;
  logic [9:0] s_frac_mod;

  rpz_unpack u_unpack (
    .bytes_i(image),
    .scale_ns_o(s_scale),
    .promo_o(s_promo),
    .sel_o(s_sel),
    .period_o(s_period),
    .inner_o(s_inner),
    .outer_o(s_outer),
    .qualify_o(s_qualify),
    .recheck_o(s_recheck),
    .c1_lin_o(s_c1_lin),
    .c1_exp_a_o(s_c1_exp_a),
    .c1_exp_b_o(s_c1_exp_b),
    .c1_exp_c_o(s_c1_exp_c),
    .c2_lin_o(s_c2_lin),
    .c2_exp_o(s_c2_exp),
    .c3_lin_o(s_c3_lin),
    .c3_exp_o(s_c3_exp),
    .c4_lin_o(s_c4_lin),
    .c4_exp_o(s_c4_exp),
    .prediv_o(s_prediv),
    .fb_int_o(s_fb_int),
    .frac_num_o(s_frac_num),
    .frac_mod_o(s_frac_mod)
  );

  // software slips are only flagged; the values are still applied
  assign promo_bad = (s_promo > s_sel);
  assign fb_low = (s_fb_int < rpz_pkg::FB_INT_MIN);

  // ----------------------------------------------------------------
  // applied copy: every field changes on one edge only
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scale_ns_o <= 1'b0;
      promo_prio_o <= 3'h0;
      sel_prio_o <= 3'h0;
      ref_period_fs_o <= 40'h00_0000_0000;
      inner_tol_o <= 20'h0_0000;
      outer_tol_o <= 20'h0_0000;
      qualify_ms_o <= 16'h0000;
      recheck_ms_o <= 16'h0000;
      c1_lin_o <= 16'h0000;
      c1_exp_a_o <= 6'h00;
      c1_exp_b_o <= 3'h0;
      c1_exp_c_o <= 4'h0;
      c2_lin_o <= 17'h0_0000;
      c2_exp_o <= 5'h00;
      c3_lin_o <= 17'h0_0000;
      c3_exp_o <= 5'h00;
      c4_lin_o <= 15'h0000;
      c4_exp_o <= 5'h00;
      prediv_ratio_o <= 31'h0000_0001;
      fb_int_ratio_o <= 21'h00_0001;
      frac_num_o <= 10'h000;
      frac_mod_o <= 10'h000;
    end else if (apply_now) begin
      scale_ns_o <= s_scale;
      promo_prio_o <= s_promo;
      sel_prio_o <= s_sel;
      ref_period_fs_o <= s_period;
      inner_tol_o <= s_inner;
      outer_tol_o <= s_outer;
      qualify_ms_o <= s_qualify;
      recheck_ms_o <= s_recheck;
      c1_lin_o <= s_c1_lin;
      c1_exp_a_o <= s_c1_exp_a;
      c1_exp_b_o <= s_c1_exp_b;
      c1_exp_c_o <= s_c1_exp_c;
      c2_lin_o <= s_c2_lin;
      c2_exp_o <= s_c2_exp;
      c3_lin_o <= s_c3_lin;
      c3_exp_o <= s_c3_exp;
      c4_lin_o <= s_c4_lin;
      c4_exp_o <= s_c4_exp;
      prediv_ratio_o <= 31'(s_prediv) + 31'h0000_0001;
      fb_int_ratio_o <= 21'(s_fb_int) + 21'h00_0001;
      frac_num_o <= s_frac_num;
      frac_mod_o <= s_frac_mod;
    end
  end

  // ----------------------------------------------------------------
  // uses of the applied priorities and scale
  // ----------------------------------------------------------------
  // one cycle behind the inputs and the applied fields
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      eff_prio_o <= 3'h0;
      phase_master_o <= 1'b0;
      lock_thresh_ps_o <= 26'h000_0000;
    end else begin
      eff_prio_o <= ref_active_i ? promo_prio_o : sel_prio_o;
      phase_master_o <= (sel_prio_o < master_thresh_i);
      lock_thresh_ps_o <= scale_ns_o
        ? 26'(lock_thresh_i) * rpz_pkg::NS_TO_PS
        : 26'(lock_thresh_i);
    end
  end

endmodule

//--- rpz_profile_bank_chk.sv
// assertions on the ports of the profile zero register bank
// assumes one clock domain and the synchronous reset of the bank
`timescale 1ns/10ps
module rpz_profile_bank_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic ref_active_i,
  input wire logic [2:0] master_thresh_i,
  input wire logic [15:0] lock_thresh_i,
  input wire logic scale_ns_o,
  input wire logic [2:0] promo_prio_o,
  input wire logic [2:0] sel_prio_o,
  input wire logic [2:0] eff_prio_o,
  input wire logic phase_master_o,
  input wire logic [25:0] lock_thresh_ps_o,
  input wire logic [39:0] ref_period_fs_o,
  input wire logic [30:0] prediv_ratio_o,
  input wire logic [20:0] fb_int_ratio_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic commit_q;
  // fields may only move on the edge that completes an apply write
  always_ff @(posedge clk_i) begin
    commit_q <= pready_o && pwrite_i &&
      paddr_i == {rpz_pkg::IDX_APPLY_CTRL, 2'b00};
  end
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    s_setup ##1 (psel_i && penable_i);
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_ready_one_wait: assert property (s_access |=> pready_o)
    else $error("ready not one cycle after access");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside ready");
  chk_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  chk_reset_ratio: assert property ($past(srst_i) |->
    prediv_ratio_o == 31'h1 && fb_int_ratio_o == 21'h1)
    else $error("ratio not one after reset");
  chk_ratio_plus_one: assert property (
    prediv_ratio_o != 31'h0 && fb_int_ratio_o != 21'h0)
    else $error("ratio of zero seen");
  chk_eff_prio: assert property (!$past(srst_i) |-> eff_prio_o ==
    ($past(ref_active_i) ? $past(promo_prio_o) : $past(sel_prio_o)))
    else $error("effective priority wrong");
  chk_phase_master: assert property (!$past(srst_i) |-> phase_master_o ==
    ($past(sel_prio_o) < $past(master_thresh_i)))
    else $error("phase master flag wrong");
  chk_lock_scale: assert property (!$past(srst_i) |->
    lock_thresh_ps_o == ($past(scale_ns_o) ?
    26'($past(lock_thresh_i)) * 26'h3e8 : 26'($past(lock_thresh_i))))
    else $error("lock threshold scaling wrong");
  chk_period_whole: assert property (
    !$past(srst_i) && $changed(ref_period_fs_o) |-> commit_q)
    else $error("period moved without apply");
  chk_fb_whole: assert property (
    !$past(srst_i) && $changed(fb_int_ratio_o) |-> commit_q)
    else $error("feedback moved without apply");
endmodule
bind rpz_profile_bank rpz_profile_bank_chk u_rpz_profile_bank_chk (
  .clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o,
  .pready_o, .pslverr_o, .ref_active_i, .master_thresh_i, .lock_thresh_i,
  .scale_ns_o, .promo_prio_o, .sel_prio_o, .eff_prio_o, .phase_master_o,
  .lock_thresh_ps_o, .ref_period_fs_o, .prediv_ratio_o, .fb_int_ratio_o);

//--- rpz_unpack.sv
// splits the staged byte image of the profile into its packed fields
// assumes bytes_i holds byte k of the profile at bits [8k+7:8k]
`timescale 1ns/10ps
module rpz_unpack (
  input wire logic [327:0] bytes_i,
  output logic scale_ns_o,
  output logic [2:0] promo_o,
  output logic [2:0] sel_o,
  output logic [39:0] period_o,
  output logic [19:0] inner_o,
  output logic [19:0] outer_o,
  output logic [15:0] qualify_o,
  output logic [15:0] recheck_o,
  output logic [15:0] c1_lin_o,
  output logic [5:0] c1_exp_a_o,
  output logic [2:0] c1_exp_b_o,
  output logic [3:0] c1_exp_c_o,
  output logic [16:0] c2_lin_o,
  output logic [4:0] c2_exp_o,
  output logic [16:0] c3_lin_o,
  output logic [4:0] c3_exp_o,
  output logic [14:0] c4_lin_o,
  output logic [4:0] c4_exp_o,
  output logic [29:0] prediv_o,
  output logic [19:0] fb_int_o,
  output logic [9:0] frac_num_o,
  output logic [9:0] frac_mod_o
);

  logic [7:0] pb [0:rpz_pkg::NUM_BYTES-1];

  // a call result cannot be bit-selected, so bytes sit in an array
  function automatic int pos(input logic [13:0] idx);
    return int'(idx - rpz_pkg::IDX_PRIORITY_AND_SCALE);
  endfunction

  always_comb begin
    for (int k = 0; k < rpz_pkg::NUM_BYTES; k++) begin
      pb[k] = bytes_i[k*8 +: 8];
    end
  end

  // ----------------------------------------------------------------
  // field assembly, low byte at the lower address
  // ----------------------------------------------------------------
  always_comb begin
    scale_ns_o =
      pb[pos(rpz_pkg::IDX_PRIORITY_AND_SCALE)][rpz_pkg::SCALE_BIT];
    promo_o =
      pb[pos(rpz_pkg::IDX_PRIORITY_AND_SCALE)][rpz_pkg::PROMO_LSB +: 3];
    sel_o =
      pb[pos(rpz_pkg::IDX_PRIORITY_AND_SCALE)][rpz_pkg::SEL_LSB +: 3];
    period_o = {pb[pos(rpz_pkg::IDX_REF_PERIOD_B4)],
      pb[pos(rpz_pkg::IDX_REF_PERIOD_B3)],
      pb[pos(rpz_pkg::IDX_REF_PERIOD_B2)],
      pb[pos(rpz_pkg::IDX_REF_PERIOD_B1)],
      pb[pos(rpz_pkg::IDX_REF_PERIOD_B0)]};
    inner_o = {pb[pos(rpz_pkg::IDX_INNER_TOL_B2)][3:0],
      pb[pos(rpz_pkg::IDX_INNER_TOL_B1)],
      pb[pos(rpz_pkg::IDX_INNER_TOL_B0)]};
    outer_o = {pb[pos(rpz_pkg::IDX_OUTER_TOL_B2)][3:0],
      pb[pos(rpz_pkg::IDX_OUTER_TOL_B1)],
      pb[pos(rpz_pkg::IDX_OUTER_TOL_B0)]};
    qualify_o = {pb[pos(rpz_pkg::IDX_QUALIFY_TIMER_HI)],
      pb[pos(rpz_pkg::IDX_QUALIFY_TIMER_LO)]};
    recheck_o = {pb[pos(rpz_pkg::IDX_RECHECK_TIMER_HI)],
      pb[pos(rpz_pkg::IDX_RECHECK_TIMER_LO)]};
    // each coefficient is lin * 2^exp; kept apart so the loop does the shift
    c1_lin_o = {pb[pos(rpz_pkg::IDX_COEF_FIRST_LIN_HI)],
      pb[pos(rpz_pkg::IDX_COEF_FIRST_LIN_LO)]};
    c1_exp_a_o = pb[pos(rpz_pkg::IDX_COEF_FIRST_EXPS)][5:0];
    c1_exp_b_o = {pb[pos(rpz_pkg::IDX_COEF_SECOND_LIN_A)][0],
      pb[pos(rpz_pkg::IDX_COEF_FIRST_EXPS)][7:6]};
    c1_exp_c_o = pb[pos(rpz_pkg::IDX_COEF_EXPS_TAIL)][7:4];
    c2_lin_o = {pb[pos(rpz_pkg::IDX_COEF_SECOND_EXP)][1:0],
      pb[pos(rpz_pkg::IDX_COEF_SECOND_LIN_B)],
      pb[pos(rpz_pkg::IDX_COEF_SECOND_LIN_A)][7:1]};
    c2_exp_o = pb[pos(rpz_pkg::IDX_COEF_SECOND_EXP)][6:2];
    c3_lin_o = {pb[pos(rpz_pkg::IDX_COEF_THIRD_EXP)][0],
      pb[pos(rpz_pkg::IDX_COEF_THIRD_LIN_HI)],
      pb[pos(rpz_pkg::IDX_COEF_THIRD_LIN_LO)]};
    c3_exp_o = pb[pos(rpz_pkg::IDX_COEF_THIRD_EXP)][5:1];
    c4_lin_o = {pb[pos(rpz_pkg::IDX_COEF_FOURTH_MIXED)][6:0],
      pb[pos(rpz_pkg::IDX_COEF_FOURTH_LIN_LO)]};
    c4_exp_o = {pb[pos(rpz_pkg::IDX_COEF_EXPS_TAIL)][3:0],
      pb[pos(rpz_pkg::IDX_COEF_FOURTH_MIXED)][7]};
    prediv_o = {pb[pos(rpz_pkg::IDX_INPUT_PREDIV_B3)][5:0],
      pb[pos(rpz_pkg::IDX_INPUT_PREDIV_B2)],
      pb[pos(rpz_pkg::IDX_INPUT_PREDIV_B1)],
      pb[pos(rpz_pkg::IDX_INPUT_PREDIV_B0)]};
    fb_int_o = {pb[pos(rpz_pkg::IDX_FEEDBACK_INT_B2)][3:0],
      pb[pos(rpz_pkg::IDX_FEEDBACK_INT_B1)],
      pb[pos(rpz_pkg::IDX_FEEDBACK_INT_B0)]};
    frac_num_o = {pb[pos(rpz_pkg::IDX_FRACTION_MIXED)][1:0],
      pb[pos(rpz_pkg::IDX_FRACTION_NUM_LO)]};
    frac_mod_o = {pb[pos(rpz_pkg::IDX_FRACTION_MOD_HI)][5:0],
      pb[pos(rpz_pkg::IDX_FRACTION_MIXED)][7:4]};
  end

endmodule

//--- tb_top.sv
// self-checking bench for the profile zero register bank
// assumes a 25 MHz clock and the one-wait-state apb slave of the bank
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [15:0] paddr_i = 16'h0000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic ref_active_i = 1'b0;
  logic [2:0] master_thresh_i = 3'h7;
  logic [15:0] lock_thresh_i = 16'hffff;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, scale_ns_o, phase_master_o, er;
  logic [2:0] promo_prio_o, sel_prio_o, eff_prio_o, c1_exp_b_o;
  logic [25:0] lock_thresh_ps_o;
  logic [39:0] ref_period_fs_o;
  logic [19:0] inner_tol_o, outer_tol_o;
  logic [15:0] qualify_ms_o, recheck_ms_o, c1_lin_o;
  logic [5:0] c1_exp_a_o;
  logic [3:0] c1_exp_c_o;
  logic [16:0] c2_lin_o, c3_lin_o;
  logic [4:0] c2_exp_o, c3_exp_o, c4_exp_o;
  logic [14:0] c4_lin_o;
  logic [30:0] prediv_ratio_o;
  logic [20:0] fb_int_ratio_o;
  logic [9:0] frac_num_o, frac_mod_o;
  logic [7:0] b [41];
  int num_errors = 0;
  int checked = 0;
  rpz_profile_bank u_rpz_profile_bank (.clk_i, .srst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .ref_active_i, .master_thresh_i, .lock_thresh_i, .scale_ns_o,
    .promo_prio_o, .sel_prio_o, .eff_prio_o, .phase_master_o,
    .lock_thresh_ps_o, .ref_period_fs_o, .inner_tol_o, .outer_tol_o,
    .qualify_ms_o, .recheck_ms_o, .c1_lin_o, .c1_exp_a_o, .c1_exp_b_o,
    .c1_exp_c_o, .c2_lin_o, .c2_exp_o, .c3_lin_o, .c3_exp_o, .c4_lin_o,
    .c4_exp_o, .prediv_ratio_o, .fb_int_ratio_o, .frac_num_o, .frac_mod_o);
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen,
      input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one idle cycle after each transfer keeps drivers single per step
  task automatic apb(input logic wr, input logic [15:0] ad,
      input logic [31:0] wd);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= ad;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) begin
      num_errors++;
      complete_run;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [15:0] ad(input int k);
    return {rpz_pkg::IDX_PRIORITY_AND_SCALE + 14'(k), 2'b00};
  endfunction
  // reserved bits read back as zero
  function automatic logic [7:0] rmask(input int k);
    case (k)
      0: return 8'hbf;
      6, 7, 37: return 8'h00;
      10, 13, 36: return 8'h0f;
      23: return 8'h7f;
      26, 33, 40: return 8'h3f;
      39: return 8'hf3;
      default: return 8'hff;
    endcase
  endfunction
  task automatic apply_and_side;
    apb(1'b1, {rpz_pkg::IDX_APPLY_CTRL, 2'b00}, 32'h0000_0001);
    ref_active_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("scale", scale_ns_o, b[0][7]);
    chk("promoted", eff_prio_o, b[0][5:3]);
    chk("master", phase_master_o, b[0][2:0] < master_thresh_i);
    chk("lock", lock_thresh_ps_o,
      b[0][7] ? 26'(lock_thresh_i) * 26'h3e8 : 26'(lock_thresh_i));
    ref_active_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("selection", eff_prio_o, b[0][2:0]);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    for (int k = 0; k < 41; k++) begin
      apb(1'b0, ad(k), 32'h0000_0000);
      chk("reset byte", rd, 0);
    end
    apb(1'b0, {rpz_pkg::IDX_BANK_STATUS, 2'b00}, 32'h0000_0000);
    chk("status reset", rd, 32'h0000_0001 << rpz_pkg::STS_FB_LOW_BIT);
    chk("prediv reset", prediv_ratio_o, 1);
    chk("fb reset", fb_int_ratio_o, 1);
    for (int k = 0; k < 41; k++) begin
      b[k] = (k == 6 || k == 7) ? 8'h00 : 8'h93 + 8'(k * 29);
      apb(1'b1, ad(k), {24'h00_0000, b[k]});
    end
    for (int k = 0; k < 41; k++) begin
      apb(1'b0, ad(k), 32'h0000_0000);
      chk("readback", {er, rd}, {25'h0, b[k] & rmask(k)});
    end
    apb(1'b0, {rpz_pkg::IDX_BANK_STATUS, 2'b00}, 32'h0000_0000);
    chk("status staged", rd,
      32'h0000_0001 << rpz_pkg::STS_PENDING_BIT);
    chk("staged only", ref_period_fs_o, 0);
    apply_and_side;
    chk("period", ref_period_fs_o, {b[5], b[4], b[3], b[2], b[1]});
    chk("inner", inner_tol_o, {b[10][3:0], b[9], b[8]});
    chk("outer", outer_tol_o, {b[13][3:0], b[12], b[11]});
    chk("qualify", qualify_ms_o, {b[15], b[14]});
    chk("recheck", recheck_ms_o, {b[17], b[16]});
    chk("c1", {c1_lin_o, c1_exp_a_o, c1_exp_b_o, c1_exp_c_o},
      {b[19], b[18], b[20][5:0], b[21][0], b[20][7:6], b[29][7:4]});
    chk("c2", {c2_lin_o, c2_exp_o},
      {b[23][1:0], b[22], b[21][7:1], b[23][6:2]});
    chk("c3", {c3_lin_o, c3_exp_o},
      {b[26][0], b[25], b[24], b[26][5:1]});
    chk("c4", {c4_lin_o, c4_exp_o},
      {b[28][6:0], b[27], b[29][3:0], b[28][7]});
    chk("prediv", prediv_ratio_o,
      {b[33][5:0], b[32], b[31], b[30]} + 31'h1);
    chk("fb", fb_int_ratio_o, {b[36][3:0], b[35], b[34]} + 21'h1);
    chk("frac", {frac_num_o, frac_mod_o},
      {b[39][1:0], b[38], b[40][5:0], b[39][7:4]});
    apb(1'b0, {rpz_pkg::IDX_BANK_STATUS, 2'b00}, 32'h0000_0000);
    chk("status applied", rd, 0);
    b[0] = 8'h0b;
    master_thresh_i <= 3'h3;
    lock_thresh_i <= 16'h1234;
    apb(1'b1, ad(0), {24'h00_0000, b[0]});
    apply_and_side;
    apb(1'b0, {14'h0680, 2'b00}, 32'h0000_0000);
    chk("unmapped", {er, rd}, {1'b1, 32'h0000_0000});
    apb(1'b0, ad(1) | 16'h0002, 32'h0000_0000);
    chk("unaligned", er, 1);
    complete_run;
  end
endmodule
